// ---- hdl/iepsl_pkg.sv ----
/*
 * iepsl_pkg: shared constants and types for the interrupt enable and
 * priority slice. Assumes a 32-bit AHB-Lite bus with word transfers only.
 */
package iepsl_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_ENABLE_BANK3 = 8'h00;
	localparam logic [7:0] ADDR_ENABLE_BANK4 = 8'h04;
	localparam logic [7:0] ADDR_PRIORITY_BASE = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h24;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h28;
	localparam logic [7:0] ADDR_PRIORITY_STRIDE = 8'h04;

	localparam int NUM_PRIO_REGS = 5;
	localparam int NUM_SRC = 25;
	localparam int NUM_EN_SRC = 8;
	localparam int NUM_PRIO_SRC = 17;
	localparam int PRIO_W = 3;

	// implemented bit masks; unimplemented bits store nothing, read zero
	localparam logic [15:0] ENABLE_BANK3_MASK = 16'h4006;
	localparam logic [15:0] ENABLE_BANK4_MASK = 16'h210E;
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	localparam logic [15:0] PRIO_MASK_0 = 16'h7777;
	localparam logic [15:0] PRIO_MASK_1 = 16'h7770;
	localparam logic [15:0] PRIO_MASK_2 = 16'h7777;
	localparam logic [15:0] PRIO_MASK_3 = 16'h0077;
	localparam logic [15:0] PRIO_MASK_4 = 16'h7777;
	// every field resets to 3'b100
	localparam logic [15:0] PRIO_RESET_ALL = 16'h4444;
	localparam logic [2:0] PRIO_OFF = 3'h0;

	// enable bit positions
	localparam int BIT_CALENDAR = 14;
	localparam int BIT_I2C2_MASTER = 2;
	localparam int BIT_I2C2_SLAVE = 1;
	localparam int BIT_CHARGE_TIME = 13;
	localparam int BIT_LOW_VOLTAGE = 8;
	localparam int BIT_CHECKSUM = 3;
	localparam int BIT_UART2_ERR = 2;
	localparam int BIT_UART1_ERR = 1;

	// priority field low bit positions
	localparam int FLD_HI = 12;
	localparam int FLD_MID = 8;
	localparam int FLD_LO = 4;
	localparam int FLD_BOT = 0;

	// source indexes: enable-slice sources first, then priority-slice
	localparam int SRC_CALENDAR = 0;
	localparam int SRC_I2C2_MASTER = 1;
	localparam int SRC_I2C2_SLAVE = 2;
	localparam int SRC_CHARGE_TIME = 3;
	localparam int SRC_LOW_VOLTAGE = 4;
	localparam int SRC_CHECKSUM = 5;
	localparam int SRC_UART2_ERR = 6;
	localparam int SRC_UART1_ERR = 7;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_READ_WAIT = 2'b10
	} iepsl_bus_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} iepsl_addr_phase_t;

	typedef struct packed {
		logic valid;
		logic [2:0] prio;
	} iepsl_request_t;

endpackage : iepsl_pkg

// ---- hdl/iepsl_slice.sv ----
/*
 * iepsl_slice: interrupt enable and priority slice with AHB-Lite register
 * access, sticky source flags, request forwarding and an event interrupt.
 * Assumes one AHB-Lite master, word-sized single transfers, and peripheral
 * flag-set pulses synchronous to hclk. Enables and priorities held outside
 * this slice arrive as plain inputs.
 */
// Behaviour
// [R1] enable bank 3 bit 14 is the writable calendar clock enable
// [R2] enable bank 3 bit 2 second I2C master, bit 1 second I2C slave
// [R3] enable bank 4 bit 13 charge-time unit, bit 8 low-voltage detect
// [R4] enable bank 4 bit 3 checksum, bit 2 second UART, bit 1 first UART error
// [R5] enable one passes a source's request, zero blocks it; all clear at reset
// [R6] three-bit priority: 7 highest down to 1, zero disables the source
// [R7] every priority field resets to 100, priority four
// [R8] unimplemented bits read zero and ignore writes
// [R9] priority bank 0: timer1 14-12, compare1 10-8, capture1 6-4, ext irq0 2-0
// [R10] priority bank 1: timer2 14-12, compare2 10-8, capture2 6-4, low nibble unused
// [R11] priority bank 2: uart1 rx 14-12, spi1 event 10-8, spi1 fault 6-4, timer3 2-0
// [R12] priority bank 3: adc done 6-4, uart1 tx 2-0, bits 15-7 unused
// [R13] priority bank 4: pin change 14-12, comparator 10-8, i2c1 master 6-4, slave 2-0
// [R14] a source flag reads one once its request occurred, zero otherwise
// [R15] forward request only when flagged, enabled, nonzero priority, tagged with priority
module iepsl_slice (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// peripheral sources
	input wire logic [iepsl_pkg::NUM_SRC-1:0] src_flag_set,
	input wire logic [iepsl_pkg::NUM_PRIO_SRC-1:0] ext_enable,
	input wire logic [iepsl_pkg::NUM_EN_SRC*iepsl_pkg::PRIO_W-1:0] ext_priority,
	// core arbitration
	output iepsl_pkg::iepsl_request_t [iepsl_pkg::NUM_SRC-1:0] core_request,
	// interrupt
	output logic irq
);

	iepsl_pkg::iepsl_bus_state_t state_q;
	iepsl_pkg::iepsl_addr_phase_t aphase_q;
	logic [15:0] enable_bank3_q;
	logic [15:0] enable_bank4_q;
	logic [15:0] prio_q [iepsl_pkg::NUM_PRIO_REGS];
	logic [15:0] prio_mask [iepsl_pkg::NUM_PRIO_REGS];
	logic [iepsl_pkg::NUM_SRC-1:0] flag_q;
	logic [iepsl_pkg::NUM_SRC-1:0] irq_status_q;
	logic [iepsl_pkg::NUM_SRC-1:0] irq_enable_q;
	logic [iepsl_pkg::NUM_SRC-1:0] req_q;
	logic [iepsl_pkg::NUM_SRC-1:0] req_d;
	logic [iepsl_pkg::NUM_SRC-1:0] src_enable;
	logic [iepsl_pkg::PRIO_W-1:0] src_prio [iepsl_pkg::NUM_SRC];
	logic [31:0] hrdata_q;
	logic [31:0] rdata_d;
	logic hreadyout_q;
	logic hresp_q;
	logic irq_q;
	logic addr_take;
	logic wr_commit;
	logic [iepsl_pkg::NUM_SRC-1:0] flag_clr;
	logic [iepsl_pkg::NUM_SRC-1:0] status_clr;

	assign prio_mask[0] = iepsl_pkg::PRIO_MASK_0;
	assign prio_mask[1] = iepsl_pkg::PRIO_MASK_1;
	assign prio_mask[2] = iepsl_pkg::PRIO_MASK_2;
	assign prio_mask[3] = iepsl_pkg::PRIO_MASK_3;
	assign prio_mask[4] = iepsl_pkg::PRIO_MASK_4;

	// bus handshake
	assign addr_take = hsel && hready && (htrans == iepsl_pkg::HTRANS_NONSEQ);
	assign wr_commit = aphase_q.valid && aphase_q.write;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aphase_q <= '0;
		end
		else if (hready)
		begin
			aphase_q.valid <= addr_take;
			aphase_q.write <= hwrite;
			aphase_q.addr <= haddr[7:0];
		end
	end

	// reads take one wait state so the read mux always sees committed writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= iepsl_pkg::BUS_IDLE;
			hreadyout_q <= 1'b1;
		end
		else
		begin
			unique case (state_q)
				iepsl_pkg::BUS_IDLE:
				begin
					if (addr_take && !hwrite)
					begin
						state_q <= iepsl_pkg::BUS_READ_WAIT;
						hreadyout_q <= 1'b0;
					end
				end
				iepsl_pkg::BUS_READ_WAIT:
				begin
					state_q <= iepsl_pkg::BUS_IDLE;
					hreadyout_q <= 1'b1;
				end
			endcase
		end
	end

	// the slave never errors
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hresp_q <= 1'b0;
		end
		else
		begin
			hresp_q <= 1'b0;
		end
	end

	// read mux; stored values are already masked [R8]
	always_comb
	begin
		rdata_d = '0;
		unique case (aphase_q.addr)
			iepsl_pkg::ADDR_ENABLE_BANK3: rdata_d[15:0] = enable_bank3_q;
			iepsl_pkg::ADDR_ENABLE_BANK4: rdata_d[15:0] = enable_bank4_q;
			iepsl_pkg::ADDR_PRIORITY_BASE: rdata_d[15:0] = prio_q[0];
			iepsl_pkg::ADDR_PRIORITY_BASE + iepsl_pkg::ADDR_PRIORITY_STRIDE:
				rdata_d[15:0] = prio_q[1];
			iepsl_pkg::ADDR_PRIORITY_BASE + 2 * iepsl_pkg::ADDR_PRIORITY_STRIDE:
				rdata_d[15:0] = prio_q[2];
			iepsl_pkg::ADDR_PRIORITY_BASE + 3 * iepsl_pkg::ADDR_PRIORITY_STRIDE:
				rdata_d[15:0] = prio_q[3];
			iepsl_pkg::ADDR_PRIORITY_BASE + 4 * iepsl_pkg::ADDR_PRIORITY_STRIDE:
				rdata_d[15:0] = prio_q[4];
			iepsl_pkg::ADDR_FLAGS: rdata_d[iepsl_pkg::NUM_SRC-1:0] = flag_q; // [R14]
			iepsl_pkg::ADDR_IRQ_STATUS: rdata_d[iepsl_pkg::NUM_SRC-1:0] = irq_status_q;
			iepsl_pkg::ADDR_IRQ_ENABLE: rdata_d[iepsl_pkg::NUM_SRC-1:0] = irq_enable_q;
			default: rdata_d = '0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata_q <= '0;
		end
		else if (state_q == iepsl_pkg::BUS_READ_WAIT)
		begin
			hrdata_q <= rdata_d;
		end
	end

	// enable registers, cleared at reset [R5]
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			enable_bank3_q <= iepsl_pkg::ENABLE_RESET;
			enable_bank4_q <= iepsl_pkg::ENABLE_RESET;
		end
		else if (wr_commit)
		begin
			if (aphase_q.addr == iepsl_pkg::ADDR_ENABLE_BANK3)
			begin
				enable_bank3_q <= hwdata[15:0] & iepsl_pkg::ENABLE_BANK3_MASK; // [R1] [R2] [R8]
			end
			if (aphase_q.addr == iepsl_pkg::ADDR_ENABLE_BANK4)
			begin
				enable_bank4_q <= hwdata[15:0] & iepsl_pkg::ENABLE_BANK4_MASK; // [R3] [R4] [R8]
			end
		end
	end

	// priority registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prio_q[0] <= iepsl_pkg::PRIO_RESET_ALL & iepsl_pkg::PRIO_MASK_0; // [R7]
			prio_q[1] <= iepsl_pkg::PRIO_RESET_ALL & iepsl_pkg::PRIO_MASK_1; // [R7]
			prio_q[2] <= iepsl_pkg::PRIO_RESET_ALL & iepsl_pkg::PRIO_MASK_2; // [R7]
			prio_q[3] <= iepsl_pkg::PRIO_RESET_ALL & iepsl_pkg::PRIO_MASK_3; // [R7]
			prio_q[4] <= iepsl_pkg::PRIO_RESET_ALL & iepsl_pkg::PRIO_MASK_4; // [R7]
		end
		else if (wr_commit)
		begin
			for (int r = 0; r < iepsl_pkg::NUM_PRIO_REGS; r++)
			begin
				if (aphase_q.addr == iepsl_pkg::ADDR_PRIORITY_BASE
					+ 8'(r) * iepsl_pkg::ADDR_PRIORITY_STRIDE)
				begin
					prio_q[r] <= hwdata[15:0] & prio_mask[r]; // [R8]
				end
			end
		end
	end

	// write-one-to-clear strobes
	assign flag_clr = (wr_commit && aphase_q.addr == iepsl_pkg::ADDR_FLAGS) ?
		hwdata[iepsl_pkg::NUM_SRC-1:0] : '0;
	assign status_clr = (wr_commit && aphase_q.addr == iepsl_pkg::ADDR_IRQ_CLEAR) ?
		hwdata[iepsl_pkg::NUM_SRC-1:0] : '0;

	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flag_q <= '0;
		end
		else
		begin
			flag_q <= (flag_q & ~flag_clr) | src_flag_set; // [R14]
		end
	end

	// enables and priorities per source
	assign src_enable[iepsl_pkg::SRC_CALENDAR] = enable_bank3_q[iepsl_pkg::BIT_CALENDAR]; // [R1]
	assign src_enable[iepsl_pkg::SRC_I2C2_MASTER] =
		enable_bank3_q[iepsl_pkg::BIT_I2C2_MASTER]; // [R2]
	assign src_enable[iepsl_pkg::SRC_I2C2_SLAVE] =
		enable_bank3_q[iepsl_pkg::BIT_I2C2_SLAVE]; // [R2]
	assign src_enable[iepsl_pkg::SRC_CHARGE_TIME] =
		enable_bank4_q[iepsl_pkg::BIT_CHARGE_TIME]; // [R3]
	assign src_enable[iepsl_pkg::SRC_LOW_VOLTAGE] =
		enable_bank4_q[iepsl_pkg::BIT_LOW_VOLTAGE]; // [R3]
	assign src_enable[iepsl_pkg::SRC_CHECKSUM] = enable_bank4_q[iepsl_pkg::BIT_CHECKSUM]; // [R4]
	assign src_enable[iepsl_pkg::SRC_UART2_ERR] = enable_bank4_q[iepsl_pkg::BIT_UART2_ERR]; // [R4]
	assign src_enable[iepsl_pkg::SRC_UART1_ERR] = enable_bank4_q[iepsl_pkg::BIT_UART1_ERR]; // [R4]
	assign src_enable[iepsl_pkg::NUM_SRC-1:iepsl_pkg::NUM_EN_SRC] = ext_enable;

	// priorities of enable-slice sources live in other banks
	for (genvar e = 0; e < iepsl_pkg::NUM_EN_SRC; e++)
	begin : g_ext_prio
		assign src_prio[e] = ext_priority[e*iepsl_pkg::PRIO_W +: iepsl_pkg::PRIO_W];
	end

	// bank 0: timer1, compare1, capture1, ext irq0
	assign src_prio[8] = prio_q[0][iepsl_pkg::FLD_HI +: iepsl_pkg::PRIO_W]; // [R9]
	assign src_prio[9] = prio_q[0][iepsl_pkg::FLD_MID +: iepsl_pkg::PRIO_W]; // [R9]
	assign src_prio[10] = prio_q[0][iepsl_pkg::FLD_LO +: iepsl_pkg::PRIO_W]; // [R9]
	assign src_prio[11] = prio_q[0][iepsl_pkg::FLD_BOT +: iepsl_pkg::PRIO_W]; // [R9]
	// bank 1: timer2, compare2, capture2
	assign src_prio[12] = prio_q[1][iepsl_pkg::FLD_HI +: iepsl_pkg::PRIO_W]; // [R10]
	assign src_prio[13] = prio_q[1][iepsl_pkg::FLD_MID +: iepsl_pkg::PRIO_W]; // [R10]
	assign src_prio[14] = prio_q[1][iepsl_pkg::FLD_LO +: iepsl_pkg::PRIO_W]; // [R10]
	// bank 2: uart1 rx, spi1 event, spi1 fault, timer3
	assign src_prio[15] = prio_q[2][iepsl_pkg::FLD_HI +: iepsl_pkg::PRIO_W]; // [R11]
	assign src_prio[16] = prio_q[2][iepsl_pkg::FLD_MID +: iepsl_pkg::PRIO_W]; // [R11]
	assign src_prio[17] = prio_q[2][iepsl_pkg::FLD_LO +: iepsl_pkg::PRIO_W]; // [R11]
	assign src_prio[18] = prio_q[2][iepsl_pkg::FLD_BOT +: iepsl_pkg::PRIO_W]; // [R11]
	// bank 3: adc done, uart1 tx
	assign src_prio[19] = prio_q[3][iepsl_pkg::FLD_LO +: iepsl_pkg::PRIO_W]; // [R12]
	assign src_prio[20] = prio_q[3][iepsl_pkg::FLD_BOT +: iepsl_pkg::PRIO_W]; // [R12]
	// bank 4: pin change, comparator, i2c1 master, i2c1 slave
	assign src_prio[21] = prio_q[4][iepsl_pkg::FLD_HI +: iepsl_pkg::PRIO_W]; // [R13]
	assign src_prio[22] = prio_q[4][iepsl_pkg::FLD_MID +: iepsl_pkg::PRIO_W]; // [R13]
	assign src_prio[23] = prio_q[4][iepsl_pkg::FLD_LO +: iepsl_pkg::PRIO_W]; // [R13]
	assign src_prio[24] = prio_q[4][iepsl_pkg::FLD_BOT +: iepsl_pkg::PRIO_W]; // [R13]

	// request gating per source
	for (genvar s = 0; s < iepsl_pkg::NUM_SRC; s++)
	begin : g_req
		// zero priority disables the source even when enabled
		assign req_d[s] = flag_q[s] && src_enable[s]
			&& (src_prio[s] != iepsl_pkg::PRIO_OFF); // [R5] [R6] [R15]
	end

	// one process owns the whole request output; tag is zero when idle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			core_request <= '0;
		end
		else
		begin
			for (int s = 0; s < iepsl_pkg::NUM_SRC; s++)
			begin
				core_request[s].valid <= req_d[s]; // [R15]
				core_request[s].prio <= req_d[s] ? src_prio[s] : iepsl_pkg::PRIO_OFF; // [R15]
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req_q <= '0;
		end
		else
		begin
			req_q <= req_d;
		end
	end

	// event status: a newly forwarded request; set wins over clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_status_q <= '0;
		end
		else
		begin
			irq_status_q <= (irq_status_q & ~status_clr) | (req_d & ~req_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_enable_q <= '0;
		end
		else if (wr_commit && aphase_q.addr == iepsl_pkg::ADDR_IRQ_ENABLE)
		begin
			irq_enable_q <= hwdata[iepsl_pkg::NUM_SRC-1:0];
		end
	end

	// one cycle behind status so the output stays a plain flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |(irq_status_q & irq_enable_q);
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign irq = irq_q;

endmodule : iepsl_slice

// ---- test/iepsl_props.sv ----
/*
 * iepsl_props: port assertions for the interrupt enable and priority slice.
 * Assumes a single AHB-Lite master whose hready is the slice's hreadyout.
 */
module iepsl_props (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// sources and core side
	input wire logic [iepsl_pkg::NUM_PRIO_SRC-1:0] ext_enable,
	input wire logic [iepsl_pkg::NUM_EN_SRC*iepsl_pkg::PRIO_W-1:0] ext_priority,
	input iepsl_pkg::iepsl_request_t [iepsl_pkg::NUM_SRC-1:0] core_request,
	input wire logic irq
);
	logic taken;
	logic req_bad;

	assign taken = hsel && hready && htrans == iepsl_pkg::HTRANS_NONSEQ;

	// a request without priority, or a priority without request, is a tag slip
	always_comb
	begin
		req_bad = 1'b0;
		for (int i = 0; i < iepsl_pkg::NUM_SRC; i++)
			req_bad |= core_request[i].valid ? core_request[i].prio == 3'h0
				: core_request[i].prio != 3'h0;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_HRESP_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_READ_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WRITE_NOWAIT: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	AST_HRDATA_HOLD: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside a read");
	AST_REQ_TAG: assert property (!req_bad)
		else $error("request and priority disagree");
	AST_EXT_PRIO_TAG: assert property (core_request[0].valid |->
		core_request[0].prio == $past(ext_priority[2:0]))
		else $error("request carries wrong priority");
	AST_EXT_EN_GATE: assert property (!ext_enable[0] |=> !core_request[8].valid)
		else $error("disabled source forwarded");
	AST_ZERO_PRIO: assert property (ext_priority[2:0] == 3'h0 |=> !core_request[0].valid)
		else $error("zero priority source forwarded");
	AST_REQ_STICKY: assert property (core_request[8].valid && ext_enable[0]
		&& !$past(taken, 2) |=> core_request[8].valid)
		else $error("request dropped without a write");

	cover property (taken && !hwrite);
	cover property ($rose(core_request[8].valid));
	cover property ($rose(irq));
endmodule : iepsl_props

bind iepsl_slice iepsl_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .ext_enable(ext_enable),
	.ext_priority(ext_priority), .core_request(core_request), .irq(irq));

// ---- test/iepsl_src_model.sv ----
/*
 * iepsl_src_model: peripheral sources raising flag-set pulses.
 * Assumes the bench commands a pulse with go and a source mask.
 */
module iepsl_src_model (
	// clock
	input wire logic hclk,
	// command
	input wire logic go,
	input wire logic [24:0] mask,
	// flag pulses
	output logic [24:0] src_flag_set
);
	timeunit 1ns;
	timeprecision 1ns;

	// one-cycle pulse, low between events as a peripheral would leave it
	always_ff @(posedge hclk)
		src_flag_set <= go ? mask : 25'h0000000;
endmodule : iepsl_src_model

// ---- test/iepsl_slice_tb.sv ----
/*
 * iepsl_slice_tb: self-checking bench for the enable and priority slice.
 * Assumes the slice, its package, the source model and the checker bind.
 */
module iepsl_slice_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, go;
	logic [31:0] haddr, hwdata, hrdata, rd_q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [24:0] src_flag_set, mask;
	logic [16:0] ext_enable;
	logic [23:0] ext_priority;
	iepsl_pkg::iepsl_request_t [24:0] core_request, exp;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	int pb[17] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 4};
	int ps[17] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 0};
	int ea[8] = '{0, 0, 0, 1, 1, 1, 1, 1};
	int eb[8] = '{14, 2, 1, 13, 8, 3, 2, 1};
	logic [15:0] pm[5] = '{16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h7777};

	assign hready = hreadyout;

	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	iepsl_slice dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_flag_set(src_flag_set),
		.ext_enable(ext_enable), .ext_priority(ext_priority), .core_request(core_request),
		.irq(irq));

	iepsl_src_model src (.hclk(hclk), .go(go), .mask(mask), .src_flag_set(src_flag_set));

	task automatic results;
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	task automatic chk(input logic [99:0] g, input logic [99:0] e);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// address held until taken, then data phase held until ready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd_q = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h00000000);
		chk(100'(rd_q), 100'(e));
	endtask : rdchk

	task automatic settle;
		repeat (4) @(posedge hclk);
	endtask : settle

	task automatic fire(input logic [24:0] m);
		go <= 1'b1;
		mask <= m;
		@(posedge hclk);
		go <= 1'b0;
		settle;
	endtask : fire

	task automatic t_regs;
		rdchk(8'h00, 32'h00000000);
		rdchk(8'h04, 32'h00000000);
		for (int b = 0; b < 5; b++)
			rdchk(8'(8 + 4 * b), {16'h0000, 16'h4444 & pm[b]});
		wr(8'h00, 32'hFFFFFFFF);
		wr(8'h04, 32'hFFFFFFFF);
		rdchk(8'h00, 32'h00004006);
		rdchk(8'h04, 32'h0000210E);
		for (int b = 0; b < 5; b++)
		begin
			wr(8'(8 + 4 * b), 32'hFFFFFFFF);
			rdchk(8'(8 + 4 * b), {16'h0000, pm[b]});
		end
		wr(8'h40, 32'hFFFFFFFF);
		rdchk(8'h40, 32'h00000000);
	endtask : t_regs

	task automatic t_prio;
		logic [15:0] v[5];
		v = '{default: 16'h0000};
		for (int i = 0; i < 17; i++)
			v[pb[i]] |= 16'((i % 7 + 1) << ps[i]);
		for (int b = 0; b < 5; b++)
			wr(8'(8 + 4 * b), {16'h0000, v[b]});
		ext_enable <= 17'h1FFFF;
		fire(25'h1FFFF00);
		exp = '0;
		for (int i = 0; i < 17; i++)
			exp[8 + i] = {1'b1, 3'(i % 7 + 1)};
		chk(core_request, exp);
		rdchk(8'h1C, 32'h01FFFF00);
		wr(8'h08, 32'h00000000);
		ext_enable <= 17'h1FF0F;
		settle;
		exp[15:8] = '0;
		chk(core_request, exp);
		wr(8'h1C, 32'h01FFFFFF);
		settle;
		chk(core_request, 100'h0);
	endtask : t_prio

	task automatic t_en;
		logic [23:0] ep;
		for (int e = 0; e < 8; e++)
			ep[3 * e +: 3] = 3'(e % 7 + 1);
		ext_priority <= ep;
		wr(8'h00, 32'h00000000);
		wr(8'h04, 32'h00000000);
		fire(25'h00000FF);
		chk(core_request, 100'h0);
		for (int e = 0; e < 8; e++)
		begin
			wr(8'(4 * ea[e]), 32'h00000001 << eb[e]);
			wr(8'(4 - 4 * ea[e]), 32'h00000000);
			settle;
			exp = '0;
			exp[e] = {1'b1, ep[3 * e +: 3]};
			chk(core_request, exp);
		end
		wr(8'h1C, 32'h01FFFFFF);
	endtask : t_en

	task automatic t_irq;
		wr(8'h24, 32'h01FFFFFF);
		wr(8'h08, 32'h00004444);
		wr(8'h28, 32'h00000100);
		fire(25'h0000100);
		chk(100'(irq), 100'h1);
		rdchk(8'h20, 32'h00000100);
		wr(8'h28, 32'h00000000);
		settle;
		chk(100'(irq), 100'h0);
		wr(8'h28, 32'h00000100);
		settle;
		chk(100'(irq), 100'h1);
		wr(8'h24, 32'h00000100);
		settle;
		chk(100'(irq), 100'h0);
		rdchk(8'h24, 32'h00000000);
		rdchk(8'h1C, 32'h00000100);
		ext_enable <= 17'h1FF0E;
		settle;
		chk(100'(core_request[8].valid), 100'h0);
	endtask : t_irq

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			error_cnt++;
			results;
		end
	end

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		go = 1'b0;
		mask = 25'h0000000;
		ext_enable = 17'h00000;
		ext_priority = 24'h000000;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_prio;
		t_en;
		t_irq;
		results;
	end
endmodule : iepsl_slice_tb
